// ==== fdso_pkg.sv ====
// Package of constants and carrier types for the disk status output block
package fdso_pkg;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int READ_PULSE_NS = 200;
    localparam int READ_WINDOW_NS = 860;
    // Pulse width is a least time: round up
    localparam int READ_PULSE_CYC = (READ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Window is a longest time: round down
    localparam int READ_WINDOW_CYC = READ_WINDOW_NS / CLK_PERIOD_NS;
    localparam int CNT_W = 7;
    localparam logic [CNT_W-1:0] PULSE_LOAD = CNT_W'(READ_PULSE_CYC);
    localparam logic [CNT_W-1:0] WINDOW_LOAD = CNT_W'(READ_WINDOW_CYC);
    localparam logic [CNT_W-1:0] CNT_ZERO = 7'h00;

    // ****************************************
    // Step phase and reset values
    // ****************************************
    localparam int PHASE_W = 2;
    localparam logic [PHASE_W-1:0] PHASE_HOME = 2'h0;
    localparam logic OUT_IDLE = 1'b1;
    localparam logic CHANGE_RESET = 1'b0;

    // ****************************************
    // Carrier types
    // ****************************************
    typedef struct packed {
        logic lever_open;
        logic carriage_home;
        logic media_protected;
        logic second_hole_seen;
    } fdso_sensor_type;

    typedef struct packed {
        logic media_change_n;
        logic home_track_flag_n;
        logic write_protect_n;
        logic double_sided_n;
        logic ready_n;
    } fdso_status_type;

    // Read qualifier states
    typedef enum logic [2:0] {
        RQ_IDLE = 3'b001,
        RQ_PULSE = 3'b010,
        RQ_HOLD = 3'b100
    } fdso_rq_state_type;
endpackage

// ==== fdso_read_shaper.sv ====
// Read transition qualifier and pulse shaper
`timescale 1ns/10ps
`default_nettype none
module fdso_read_shaper (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic flux_raw,
    input wire logic writing,
    output logic pulse_n
);
    import fdso_pkg::*;

    logic flux_d_r;
    logic [CNT_W-1:0] cnt_r;
    fdso_rq_state_type state_r;
    logic edge_seen;

    // Edge detector on the digitized transition
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            flux_d_r <= 1'b0;
        end else begin
            flux_d_r <= flux_raw;
        end
    end
    assign edge_seen = flux_raw & ~flux_d_r;

    // Window one-shot: edges inside the dead window are dropped
    always_ff @(posedge clk) begin
        if (!reset_n || writing) begin
            state_r <= RQ_IDLE;
            cnt_r <= CNT_ZERO;
            pulse_n <= OUT_IDLE;
        end else begin
            case (state_r)
                RQ_IDLE: begin
                    if (edge_seen) begin
                        state_r <= RQ_PULSE;
                        cnt_r <= PULSE_LOAD - 7'h01;
                        pulse_n <= 1'b0;
                    end
                end
                RQ_PULSE: begin
                    if (cnt_r == CNT_ZERO) begin
                        state_r <= RQ_HOLD;
                        cnt_r <= WINDOW_LOAD - PULSE_LOAD - 7'h01;
                        pulse_n <= OUT_IDLE;
                    end else begin
                        cnt_r <= cnt_r - 7'h01;
                    end
                end
                RQ_HOLD: begin
                    if (cnt_r == CNT_ZERO) begin
                        state_r <= RQ_IDLE;
                    end else begin
                        cnt_r <= cnt_r - 7'h01;
                    end
                end
                default: begin
                    state_r <= RQ_IDLE;
                    pulse_n <= OUT_IDLE;
                end
            endcase
        end
    end

    // Pulse stays low exactly the shaped width
    chk_pulse_width: assert property (@(posedge clk)
        disable iff (!reset_n || writing)
        $fell(pulse_n) |-> !pulse_n [*8] ##1 !pulse_n [*8] ##1 !pulse_n [*4] ##1 pulse_n)
        else $error("read pulse differs from shaped width");
    chk_pulse_none_writing: assert property (@(posedge clk) disable iff (!reset_n)
        writing |=> pulse_n)
        else $error("read pulse while writing");
    chk_pulse_from_edge: assert property (@(posedge clk)
        disable iff (!reset_n || writing)
        $fell(pulse_n) |-> $past(edge_seen))
        else $error("read pulse without a transition");
    chk_window_gap: assert property (@(posedge clk)
        disable iff (!reset_n || writing)
        $rose(pulse_n) |-> pulse_n [*8])
        else $error("pulse inside dead window");
endmodule
`default_nettype wire

// ==== fdso_status_outputs.sv ====
// Status and read pulse outputs of the flexible disk unit
// Functional notes
// - Open lever clears media-change latch; interface shows change true, low.
// - Select deassert edge sets latch, making change status false.
// - Home-track output low while selected and head sits at outermost track.
// - Home-track needs position sensor, step phase 0 and unit select.
// - Position sensor trips between tracks 2 and 3; phase qualifies it.
// - Write-protect output low when selected with protected media, else high.
// - Write electronics inhibited whenever protected media sensed, select ignored.
// - Each flux transition gives a 200 ns low read pulse when selected.
// - Read pulse falling edge marks the flux transition position.
// - Transitions qualified by edge detector and about 860 ns window.
// - No read pulses while writing to the media.
// - Second index hole media and selected drives double-sided output low.
// - Ready forced false when head 1 chosen with single-sided media.
// - Side select low picks head 1, high picks head 0; kept stable.
`timescale 1ns/10ps
`default_nettype none
module fdso_status_outputs (
    input wire logic clk,
    input wire logic reset_n,
    input wire fdso_pkg::fdso_sensor_type sensors,
    input wire logic [fdso_pkg::PHASE_W-1:0] step_phase,
    input wire logic unit_select,
    input wire logic side_select_n,
    input wire logic write_enable_gate_n,
    input wire logic write_pulse_line,
    input wire logic ready_base,
    input wire logic flux_raw,
    output fdso_pkg::fdso_status_type status,
    output logic read_pulse_n,
    output logic write_current_en,
    output logic write_flux
);
    import fdso_pkg::*;

    // ****************************************
    // Sensor synchronizers
    // ****************************************
    fdso_sensor_type sens_meta_r;
    fdso_sensor_type sens_r;
    logic select_d_r;
    logic change_latch_r;
    logic media_protect_internal_n;
    logic head_one;
    logic writing;
    logic write_pulse_d_r;
    logic shaped_n;

    // Two stages so the latched outputs never see a metastable sensor
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sens_meta_r <= '0;
            sens_r <= '0;
        end else begin
            sens_meta_r <= sensors;
            sens_r <= sens_meta_r;
        end
    end

    // ****************************************
    // Media-change latch
    // ****************************************
    // Open lever wins over the select edge: a change must never be lost
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            select_d_r <= 1'b0;
            change_latch_r <= CHANGE_RESET;
        end else begin
            select_d_r <= unit_select;
            if (sens_r.lever_open) begin
                change_latch_r <= 1'b0;
            end else if (select_d_r && !unit_select) begin
                change_latch_r <= 1'b1;
            end
        end
    end

    // ****************************************
    // Interface status
    // ****************************************
    assign media_protect_internal_n = ~sens_r.media_protected;
    assign head_one = ~side_select_n;
    assign writing = ~write_enable_gate_n & unit_select & media_protect_internal_n;

    // All status lines are registered so they cannot glitch
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            status <= '1;
        end else begin
            status.media_change_n <= change_latch_r;
            // Sensor alone is ambiguous over three tracks; phase picks track 0
            status.home_track_flag_n <= ~(sens_r.carriage_home && step_phase == PHASE_HOME
                && unit_select);
            status.write_protect_n <= ~(unit_select && sens_r.media_protected);
            status.double_sided_n <= ~(unit_select && sens_r.second_hole_seen);
            status.ready_n <= ~(ready_base && unit_select
                && !(head_one && !sens_r.second_hole_seen));
        end
    end

    // ****************************************
    // Write path gating
    // ****************************************
    // Host should idle the pulse line when gate is off; gated here anyway
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            write_current_en <= 1'b0;
            write_pulse_d_r <= 1'b1;
            write_flux <= 1'b0;
        end else begin
            write_current_en <= writing;
            write_pulse_d_r <= write_pulse_line;
            if (writing && write_pulse_d_r && !write_pulse_line) begin
                write_flux <= ~write_flux;
            end
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    fdso_read_shaper u_shaper (
        .clk(clk),
        .reset_n(reset_n),
        .flux_raw(flux_raw),
        .writing(writing),
        .pulse_n(shaped_n)
    );

    // Select gating after the shaper keeps the edge timing intact
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            read_pulse_n <= OUT_IDLE;
        end else begin
            read_pulse_n <= shaped_n | ~unit_select;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    chk_change_on_open: assert property (@(posedge clk) disable iff (!reset_n)
        sens_r.lever_open |-> ##2 !status.media_change_n)
        else $error("media change not shown after open lever");
    chk_change_on_deselect: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(unit_select) && !sens_r.lever_open ##1 !sens_r.lever_open [*2]
        |-> status.media_change_n)
        else $error("media change not cleared by deselect");
    chk_home_qualified: assert property (@(posedge clk) disable iff (!reset_n)
        !status.home_track_flag_n |-> $past(unit_select) && $past(step_phase) == PHASE_HOME
        && $past(sens_r.carriage_home))
        else $error("home track without qualifiers");
    chk_home_held: assert property (@(posedge clk) disable iff (!reset_n)
        unit_select && sens_r.carriage_home && step_phase == PHASE_HOME
        |=> !status.home_track_flag_n)
        else $error("home track released at track 0");
    chk_protect_output: assert property (@(posedge clk) disable iff (!reset_n)
        ##1 status.write_protect_n == !($past(unit_select) && $past(sens_r.media_protected)))
        else $error("write protect output wrong");
    chk_write_inhibit: assert property (@(posedge clk) disable iff (!reset_n)
        sens_r.media_protected |=> !write_current_en)
        else $error("write enabled on protected media");
    chk_two_sided: assert property (@(posedge clk) disable iff (!reset_n)
        unit_select && sens_r.second_hole_seen |=> !status.double_sided_n)
        else $error("double sided not reported");
    chk_ready_side: assert property (@(posedge clk) disable iff (!reset_n)
        head_one && !sens_r.second_hole_seen |=> status.ready_n)
        else $error("ready true with head 1 on single sided media");
    chk_read_select: assert property (@(posedge clk) disable iff (!reset_n)
        !unit_select |=> read_pulse_n)
        else $error("read pulse while deselected");

    // ****************************************
    // Release and gating checks
    // ****************************************
    // Flag lets go as soon as the carriage leaves the sensor
    chk_home_release: assert property (@(posedge clk) disable iff (!reset_n)
        !sens_r.carriage_home |=> status.home_track_flag_n)
        else $error("home track shown away from the sensor");
    // Sensor alone spans three tracks, so a wrong phase must keep the flag off
    chk_home_phase: assert property (@(posedge clk) disable iff (!reset_n)
        step_phase != PHASE_HOME |=> status.home_track_flag_n)
        else $error("home track shown off phase 0");
    // Select gates the interface line only, never the internal inhibit
    chk_protect_deselect: assert property (@(posedge clk) disable iff (!reset_n)
        !unit_select |=> status.write_protect_n)
        else $error("write protect shown while deselected");
    // Two sided line needs both the hole and the select
    chk_two_sided_off: assert property (@(posedge clk) disable iff (!reset_n)
        !(unit_select && sens_r.second_hole_seen) |=> status.double_sided_n)
        else $error("double sided shown without cause");
    // Ready passes through while selected unless head 1 meets single sided media
    chk_ready_true: assert property (@(posedge clk) disable iff (!reset_n)
        ready_base && unit_select && !(head_one && !sens_r.second_hole_seen)
        |=> !status.ready_n)
        else $error("ready withheld without cause");
    // Write current follows the internal write condition one cycle late
    chk_current_on: assert property (@(posedge clk) disable iff (!reset_n)
        writing |=> write_current_en)
        else $error("write current missing while writing");
    // No flux change reaches the head unless writing is allowed
    chk_flux_gated: assert property (@(posedge clk) disable iff (!reset_n)
        !writing |=> $stable(write_flux))
        else $error("write flux toggled while inhibited");
    // Shaper reset plus output register: two cycles to clear the line
    chk_read_blocked: assert property (@(posedge clk) disable iff (!reset_n)
        writing |-> ##2 read_pulse_n)
        else $error("read pulse on interface while writing");
    // Latch sets only on the select falling edge with the lever shut
    chk_latch_set: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(change_latch_r) |-> $past(select_d_r) && !$past(unit_select)
        && !$past(sens_r.lever_open))
        else $error("media change latch set without deselect");
    // Latch clears only from an open lever, reset aside
    chk_latch_clear: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(change_latch_r) && $past(reset_n) |-> $past(sens_r.lever_open))
        else $error("media change latch cleared without open lever");
    // Sensors reach the status logic exactly two cycles late
    chk_sync_delay: assert property (@(posedge clk) disable iff (!reset_n)
        $past(reset_n) && $past(reset_n, 2) |-> sens_r == $past(sensors, 2))
        else $error("sensor synchronizer delay wrong");
endmodule
`default_nettype wire

// ==== fdso_host_model.sv ====
// Behavioural host controller driving the write gate and write data lines
`timescale 1ns/10ps
`default_nettype none
module fdso_host_model (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic want_write,
    input wire logic bold,
    input wire logic data_tick,
    input wire logic write_protect_n,
    output logic write_enable_gate_n,
    output logic write_pulse_line
);
    // ****************************************
    // Write gate: no new write while protection is reported, unless bold is set
    // ****************************************
    always_ff @(posedge clk) begin
        if (!reset_n || !want_write) begin
            write_enable_gate_n <= 1'h1;
        end else if (write_enable_gate_n && (write_protect_n || bold)) begin
            write_enable_gate_n <= 1'h0;
        end
    end
    // Data line idles high with the gate off; bold only to provoke the inhibit
    always_ff @(posedge clk) begin
        if (!reset_n || write_enable_gate_n) begin
            write_pulse_line <= 1'h1;
        end else if (data_tick) begin
            write_pulse_line <= ~write_pulse_line;
        end
    end
endmodule
`default_nettype wire

// ==== flexible_disk_status_outputs_tb.sv ====
// Self-checking testbench of the disk status output block
`timescale 1ns/10ps
`default_nettype none
`define CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin err_count++; \
    $display("[FAIL] %0t got %0h expected %0h", $time, got, exp); end end
module flexible_disk_status_outputs_tb;
    import fdso_pkg::*;
    typedef struct packed {
        logic [3:0] sens;
        logic [1:0] phase;
        logic sel;
        logic side_n;
        logic rdy;
        logic [3:0] exp;
    } fdso_row_type;
    logic clk = 1'h0;
    logic reset_n = 1'h0;
    fdso_sensor_type sensors = 4'h0;
    logic [1:0] step_phase = 2'h0;
    logic unit_select = 1'h0;
    logic side_select_n = 1'h1;
    logic ready_base = 1'h0;
    logic flux_raw = 1'h0;
    logic want_write = 1'h0;
    logic bold = 1'h0;
    logic data_tick = 1'h0;
    logic write_enable_gate_n;
    logic write_pulse_line;
    fdso_status_type status;
    logic read_pulse_n;
    logic write_current_en;
    logic write_flux;
    int err_count = 0;
    int comparisons = 0;
    int first_low;
    int lows;
    int flips;
    // Expected bits: home track, protect, double sided, ready (all low true)
    fdso_row_type rows [8] = '{
        {4'h4, 2'h0, 1'h1, 1'h1, 1'h1, 4'h6}, {4'h4, 2'h1, 1'h1, 1'h1, 1'h1, 4'hE},
        {4'h4, 2'h0, 1'h0, 1'h1, 1'h1, 4'hF}, {4'h2, 2'h3, 1'h1, 1'h1, 1'h0, 4'hB},
        {4'h2, 2'h0, 1'h0, 1'h1, 1'h1, 4'hF}, {4'h1, 2'h2, 1'h1, 1'h0, 1'h1, 4'hC},
        {4'h0, 2'h0, 1'h1, 1'h0, 1'h1, 4'hF}, {4'h0, 2'h0, 1'h1, 1'h1, 1'h1, 4'hE}};

    always #5 clk = ~clk;

    fdso_status_outputs i_dut (.clk(clk), .reset_n(reset_n), .sensors(sensors),
        .step_phase(step_phase), .unit_select(unit_select), .side_select_n(side_select_n),
        .write_enable_gate_n(write_enable_gate_n), .write_pulse_line(write_pulse_line),
        .ready_base(ready_base), .flux_raw(flux_raw), .status(status),
        .read_pulse_n(read_pulse_n), .write_current_en(write_current_en),
        .write_flux(write_flux));
    fdso_host_model i_host (.clk(clk), .reset_n(reset_n), .want_write(want_write),
        .bold(bold), .data_tick(data_tick), .write_protect_n(status.write_protect_n),
        .write_enable_gate_n(write_enable_gate_n), .write_pulse_line(write_pulse_line));

    // ****************************************
    // Helpers
    // ****************************************
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Single high cycle on the raw read line
    task automatic flux_edge;
        cyc(1);
        flux_raw = 1'h1;
        cyc(1);
        flux_raw = 1'h0;
    endtask
    // Counts read pulse low cycles and write flux toggles
    task automatic measure(input int span);
        logic last;
        last = write_flux;
        first_low = 0;
        lows = 0;
        flips = 0;
        for (int i = 1; i <= span; i++) begin
            cyc(1);
            if (read_pulse_n !== 1'h1) begin
                lows++;
                if (first_low == 0) first_low = i;
            end
            if (write_flux !== last) flips++;
            last = write_flux;
        end
    endtask
    // Eight data ticks alongside a read transition
    task automatic write_burst;
        fork
            begin data_tick = 1'h1; cyc(8); data_tick = 1'h0; end
            flux_edge();
        join_none
        measure(30);
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // Hang guard, far beyond the fewer than 500 cycles the tests need
    initial begin
        #100000;
        err_count++;
        conclude();
    end

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        cyc(8);
        `CHECK(status, 5'h1F)
        `CHECK({read_pulse_n, write_current_en, write_flux}, 3'h4)
        reset_n = 1'h1;
        cyc(2);
        `CHECK(status.media_change_n, 1'h0)
        $display("reset test done");
        foreach (rows[k]) begin
            sensors = rows[k].sens;
            step_phase = rows[k].phase;
            unit_select = rows[k].sel;
            side_select_n = rows[k].side_n;
            ready_base = rows[k].rdy;
            cyc(4);
            `CHECK(status[3:0], rows[k].exp)
        end
        $display("status table done");
        // Latch cleared by the lever, set only by the select falling edge
        sensors = 4'h8;
        cyc(4);
        `CHECK(status.media_change_n, 1'h0)
        sensors = 4'h0;
        cyc(4);
        `CHECK(status.media_change_n, 1'h0)
        unit_select = 1'h0;
        cyc(3);
        `CHECK(status.media_change_n, 1'h1)
        $display("media change test done");
        unit_select = 1'h1;
        flux_edge();
        measure(40);
        `CHECK(first_low inside {[1:2]}, 1'h1)
        `CHECK(lows, 20)
        flux_edge(); // Inside the window, must be dropped
        measure(100);
        `CHECK(lows, 0)
        flux_edge();
        measure(40);
        `CHECK(lows, 20)
        cyc(60); // Let the dead window run out so the select gate is what blocks
        unit_select = 1'h0;
        flux_edge();
        measure(100);
        `CHECK(lows, 0)
        $display("read pulse test done");
        unit_select = 1'h1;
        want_write = 1'h1;
        cyc(3);
        `CHECK(write_current_en, 1'h1)
        write_burst();
        `CHECK(flips, 4)
        `CHECK(lows, 0)
        want_write = 1'h0;
        cyc(3);
        `CHECK(write_current_en, 1'h0)
        sensors = 4'h2;
        bold = 1'h1;
        cyc(4);
        want_write = 1'h1;
        cyc(3);
        `CHECK(write_current_en, 1'h0)
        write_burst();
        `CHECK(flips, 0)
        `CHECK(lows, 20)
        want_write = 1'h0;
        $display("write path test done");
        conclude();
    end
endmodule
`default_nettype wire
